// [rtl/csc_pkg.sv]
// Purpose: Shared constants and types of the system clock select block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: Register indices times four give the byte address
package csc_pkg;

  // ==========================================================
  // Register map (index, byte address is index * 4)
  localparam logic [7:0] CSC_IDX_CLOCK_MODE = 8'h03;
  localparam logic [7:0] CSC_IDX_XTAL_CTRL = 8'h0b;
  localparam logic [7:0] CSC_IDX_STATUS = 8'h0c;

  // ==========================================================
  // Clock mode values and fields
  localparam logic [7:0] CSC_CM_DIV2 = 8'h34;
  localparam logic [7:0] CSC_CM_DIV4 = 8'h14;
  localparam logic [7:0] CSC_CM_DIV8 = 8'h3c;
  localparam logic [7:0] CSC_CM_DIV16 = 8'h1c;
  localparam logic [7:0] CSC_CM_DIV32 = 8'h7c;
  localparam logic [7:0] CSC_CM_SLOW = 8'he4;
  localparam logic [7:0] CSC_CM_BOOT_DIV64 = 8'h74;
  localparam logic [7:0] CSC_CM_RESET = 8'hf4;
  localparam int CSC_CM_FAST_EN_BIT = 4;
  localparam int CSC_CM_SLOW_EN_BIT = 2;
  // Source select code is {mode[7:5], mode[3]}
  localparam logic [3:0] CSC_SEL_DIV2 = 4'h2;
  localparam logic [3:0] CSC_SEL_DIV4 = 4'h0;
  localparam logic [3:0] CSC_SEL_DIV8 = 4'h3;
  localparam logic [3:0] CSC_SEL_DIV16 = 4'h1;
  localparam logic [3:0] CSC_SEL_DIV32 = 4'h7;
  localparam logic [3:0] CSC_SEL_DIV64 = 4'h6;
  localparam logic [3:0] CSC_SEL_SLOW = 4'he;
  localparam logic [3:0] CSC_SEL_XTAL = 4'ha;

  // ==========================================================
  // Crystal control fields and reset values
  localparam int CSC_XC_EN_BIT = 7;
  localparam int CSC_XC_DRV_MSB = 6;
  localparam int CSC_XC_DRV_LSB = 5;
  localparam logic [7:0] CSC_XC_RESET = 8'h00;

  // ==========================================================
  // Calibration directive options
  localparam logic [2:0] CSC_OPT_DIV2 = 3'h0;
  localparam logic [2:0] CSC_OPT_DIV4 = 3'h1;
  localparam logic [2:0] CSC_OPT_DIV8 = 3'h2;
  localparam logic [2:0] CSC_OPT_DIV16 = 3'h3;
  localparam logic [2:0] CSC_OPT_DIV32 = 3'h4;
  localparam logic [2:0] CSC_OPT_SLOW = 3'h5;
  localparam logic [2:0] CSC_BOOT_WAIT = 3'h4;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {CSC_SRC_FAST, CSC_SRC_SLOW, CSC_SRC_XTAL} csc_src_t;
  typedef enum logic [0:0] {CSC_ST_RUN, CSC_ST_ALIGN} csc_state_t;
  typedef struct packed {
    csc_src_t src;
    logic [2:0] divlog;
  } csc_cfg_t;
  typedef struct packed {
    logic fast;
    logic slow;
    logic xtal;
  } csc_osc_t;
  typedef struct packed {
    logic [2:0] opt;
    logic boot_fast;
    csc_osc_t osc;
  } csc_pins_t;

endpackage : csc_pkg

// [rtl/csc_sync3.sv]
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes: Output follows only when the second and third stages agree
`timescale 1ns/10ps
module csc_sync3 import csc_pkg::*; #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } csc_sync_st_t;

  csc_sync_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.q;

endmodule : csc_sync3

// [rtl/csc_clock_ctrl.sv]
// Purpose: System clock source select, divider and oscillator enables
// Assumes: Oscillator levels arrive as asynchronous pins, sampled at clk
// Notes: Output clock is rebuilt from sampled levels; no runt periods
`timescale 1ns/10ps
module csc_clock_ctrl import csc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Oscillator levels and boot straps
  input wire logic fast_internal_rc,
  input wire logic slow_internal_rc,
  input wire logic crystal_oscillator,
  input wire logic [2:0] calibration_directive,
  input wire logic boot_fast,
  // Oscillator controls
  output logic fast_rc_en,
  output logic slow_rc_en,
  output logic crystal_en,
  output logic [1:0] crystal_drive,
  // System side
  output logic system_clock_select,
  output logic watchdog_en,
  output logic port_a_pin_five_input
);

  typedef struct packed {
    logic [2:0] boot_cnt;
    logic boot_done;
    logic [7:0] clock_mode;
    logic [7:0] xtal_ctrl;
    logic wdt_en;
    logic dph_wr;
    logic [7:0] dph_idx;
    logic [31:0] rdata;
    csc_cfg_t act;
    csc_state_t fsm;
    logic fast_prev;
    logic [5:0] fast_cnt;
    logic sys_clk;
  } csc_state_s_t;

  csc_state_s_t s_q, s_d;
  csc_pins_t pins_raw, pins;

  // ==========================================================
  // Pin synchronisers
  assign pins_raw = '{opt: calibration_directive, boot_fast: boot_fast,
                      osc: '{fast: fast_internal_rc, slow: slow_internal_rc,
                             xtal: crystal_oscillator}};

  csc_sync3 #(.W($bits(csc_pins_t))) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .din(pins_raw),
    .dout(pins)
  );

  // ==========================================================
  // Mode decode
  function automatic csc_cfg_t decode_mode(input logic [7:0] cm);
    csc_cfg_t c;
    c.src = CSC_SRC_FAST;
    c.divlog = 3'd6;
    unique case ({cm[7:5], cm[3]})
      CSC_SEL_DIV2: c.divlog = 3'd1;
      CSC_SEL_DIV4: c.divlog = 3'd2;
      CSC_SEL_DIV8: c.divlog = 3'd3;
      CSC_SEL_DIV16: c.divlog = 3'd4;
      CSC_SEL_DIV32: c.divlog = 3'd5;
      CSC_SEL_DIV64: c.divlog = 3'd6;
      CSC_SEL_SLOW: begin
        c.src = CSC_SRC_SLOW;
        c.divlog = 3'd0;
      end
      // Bit 3 is a don't-care for the crystal, so both crystal codes pick it
      CSC_SEL_XTAL, CSC_SEL_XTAL | 4'h1: begin
        c.src = CSC_SRC_XTAL;
        c.divlog = 3'd0;
      end
      // Unlisted codes fall back to the slowest fast ratio
      default: c.divlog = 3'd6;
    endcase
    return c;
  endfunction : decode_mode

  function automatic logic src_level(input csc_cfg_t c, input csc_osc_t o,
                                     input logic [5:0] cnt, input logic [7:0] cm,
                                     input logic [7:0] xc);
    logic l;
    l = 1'b0;
    unique case (c.src)
      CSC_SRC_FAST: l = cm[CSC_CM_FAST_EN_BIT] & cnt[c.divlog - 3'd1];
      CSC_SRC_SLOW: l = cm[CSC_CM_SLOW_EN_BIT] & o.slow;
      CSC_SRC_XTAL: l = xc[CSC_XC_EN_BIT] & o.xtal;
    endcase
    return l;
  endfunction : src_level

  csc_cfg_t want;
  logic addr_ok;
  logic new_lvl;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    addr_ok = hsel & htrans[1] & hready;

    // Boot load after straps have settled through the synchroniser
    if (!s_q.boot_done) begin
      s_d.boot_cnt = s_q.boot_cnt + 3'd1;
      if (s_q.boot_cnt == CSC_BOOT_WAIT) begin
        s_d.boot_done = 1'b1;
        s_d.wdt_en = 1'b0;
        unique case (pins.opt)
          CSC_OPT_DIV2: s_d.clock_mode = CSC_CM_DIV2;
          CSC_OPT_DIV4: s_d.clock_mode = CSC_CM_DIV4;
          CSC_OPT_DIV8: s_d.clock_mode = CSC_CM_DIV8;
          CSC_OPT_DIV16: s_d.clock_mode = CSC_CM_DIV16;
          CSC_OPT_DIV32: s_d.clock_mode = CSC_CM_DIV32;
          CSC_OPT_SLOW: s_d.clock_mode = CSC_CM_SLOW;
          default: begin
            s_d.wdt_en = 1'b1;
            s_d.clock_mode = pins.boot_fast ? CSC_CM_BOOT_DIV64 : CSC_CM_RESET;
          end
        endcase
      end
    end

    // Bus data phase: writes land here, clock mode takes effect at once
    if (s_q.dph_wr && s_q.boot_done) begin
      if (s_q.dph_idx == CSC_IDX_CLOCK_MODE) begin
        s_d.clock_mode = hwdata[7:0];
      end else if (s_q.dph_idx == CSC_IDX_XTAL_CTRL) begin
        s_d.xtal_ctrl = hwdata[7:0];
      end
    end

    // Address phase; read data sampled from post-write values
    s_d.dph_wr = addr_ok & hwrite;
    s_d.dph_idx = haddr[9:2];
    if (addr_ok && !hwrite) begin
      if (haddr[9:2] == CSC_IDX_CLOCK_MODE) begin
        s_d.rdata = {24'h000000, s_d.clock_mode};
      end else if (haddr[9:2] == CSC_IDX_XTAL_CTRL) begin
        s_d.rdata = {24'h000000, s_d.xtal_ctrl};
      end else if (haddr[9:2] == CSC_IDX_STATUS) begin
        s_d.rdata = {24'h000000, 1'b0, pins.opt, s_q.sys_clk, s_q.fsm == CSC_ST_ALIGN,
                     s_q.wdt_en, s_q.boot_done};
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end

    // Fast RC ratio counter, advanced on each sampled rising edge
    s_d.fast_prev = pins.osc.fast;
    if (pins.osc.fast && !s_q.fast_prev) begin
      s_d.fast_cnt = s_q.fast_cnt + 6'd1;
    end

    // Glitch-free switch: change source only while output is low,
    // then hold low until the new source is low too
    want = decode_mode(s_q.clock_mode);
    new_lvl = src_level(s_q.act, pins.osc, s_q.fast_cnt, s_q.clock_mode, s_q.xtal_ctrl);
    unique case (s_q.fsm)
      CSC_ST_RUN: begin
        if (want != s_q.act && !s_q.sys_clk) begin
          s_d.act = want;
          s_d.fsm = CSC_ST_ALIGN;
          s_d.sys_clk = 1'b0;
        end else begin
          // A disabled source stops the clock; that is the hang software avoids
          s_d.sys_clk = new_lvl;
        end
      end
      CSC_ST_ALIGN: begin
        s_d.sys_clk = 1'b0;
        if (!new_lvl) begin
          s_d.fsm = CSC_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{boot_cnt: 3'h0, boot_done: 1'b0, clock_mode: CSC_CM_RESET,
               xtal_ctrl: CSC_XC_RESET, wdt_en: 1'b1, dph_wr: 1'b0, dph_idx: 8'h00,
               rdata: 32'h00000000, act: '{src: CSC_SRC_SLOW, divlog: 3'd0},
               fsm: CSC_ST_RUN, fast_prev: 1'b0, fast_cnt: 6'h00, sys_clk: 1'b0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata = s_q.rdata;
  // Stall the bus while frozen so that no transfer is silently dropped
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign fast_rc_en = s_q.clock_mode[CSC_CM_FAST_EN_BIT];
  assign slow_rc_en = s_q.clock_mode[CSC_CM_SLOW_EN_BIT];
  assign crystal_en = s_q.xtal_ctrl[CSC_XC_EN_BIT];
  assign crystal_drive = s_q.xtal_ctrl[CSC_XC_DRV_MSB:CSC_XC_DRV_LSB];
  assign system_clock_select = s_q.sys_clk;
  assign watchdog_en = s_q.wdt_en;
  // Port A pin five is left an input in every boot mode
  assign port_a_pin_five_input = 1'b1;

  // ==========================================================
  // Assertions
  a_boot_div8: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.boot_done) && $past(pins.opt) == CSC_OPT_DIV8 |-> s_q.clock_mode == CSC_CM_DIV8)
    else $error("divide-by-8 boot value wrong");
  a_boot_div16: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.boot_done) && $past(pins.opt) == CSC_OPT_DIV16 |-> s_q.clock_mode == CSC_CM_DIV16)
    else $error("divide-by-16 boot value wrong");
  a_boot_div32: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.boot_done) && $past(pins.opt) == CSC_OPT_DIV32 |-> s_q.clock_mode == CSC_CM_DIV32)
    else $error("divide-by-32 boot value wrong");
  a_boot_slow_rc: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.boot_done) && $past(pins.opt) == CSC_OPT_SLOW |-> !fast_rc_en && slow_rc_en)
    else $error("slow RC boot leaves fast RC on");
  a_boot_div2: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.boot_done) && $past(pins.opt) == CSC_OPT_DIV2 |-> s_q.clock_mode == CSC_CM_DIV2)
    else $error("divide-by-2 boot value wrong");
  a_boot_wdt_off: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.boot_done) && $past(pins.opt) <= CSC_OPT_SLOW |-> !watchdog_en && slow_rc_en)
    else $error("calibrated boot leaves watchdog on");
  a_boot_disable: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.boot_done) && $past(pins.opt) > CSC_OPT_SLOW |-> watchdog_en)
    else $error("uncalibrated boot disables watchdog");
  a_xtal_enable: assert property (@(posedge clk) disable iff (!rst_n)
    ce && s_q.dph_wr && s_q.boot_done && s_q.dph_idx == CSC_IDX_XTAL_CTRL
    |=> crystal_en == $past(hwdata[7]) && crystal_drive == $past(hwdata[6:5]))
    else $error("crystal control write not applied");
  a_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
    ce && s_q.dph_wr && s_q.boot_done && s_q.dph_idx == CSC_IDX_CLOCK_MODE
    |=> s_q.clock_mode == $past(hwdata[7:0]) && fast_rc_en == $past(hwdata[4]))
    else $error("clock mode write not applied");
  a_no_runt: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.act != $past(s_q.act) |-> !system_clock_select && !$past(system_clock_select))
    else $error("source changed while clock high");
  a_align_low: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.fsm == CSC_ST_ALIGN |-> !system_clock_select)
    else $error("clock high during alignment");
  a_xtal_decode: assert property (@(posedge clk) disable iff (!rst_n)
    ce && s_q.fsm == CSC_ST_RUN && !s_q.sys_clk && s_q.clock_mode[7:5] == CSC_SEL_XTAL[3:1]
    |=> s_q.act.src == CSC_SRC_XTAL)
    else $error("crystal code not decoded");
  a_slow_enable: assert property (@(posedge clk) disable iff (!rst_n)
    ce && s_q.dph_wr && s_q.boot_done && s_q.dph_idx == CSC_IDX_CLOCK_MODE
    |=> slow_rc_en == $past(hwdata[2]))
    else $error("slow RC enable write not applied");
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(system_clock_select) && $stable(hrdata) && $stable(s_q.clock_mode))
    else $error("state moved while clock enable low");

  c_to_xtal: cover property (@(posedge clk) disable iff (!rst_n)
    s_q.act.src == CSC_SRC_XTAL && s_q.fsm == CSC_ST_RUN && system_clock_select);
  c_to_fast2: cover property (@(posedge clk) disable iff (!rst_n)
    $past(s_q.act.src) == CSC_SRC_SLOW && s_q.act.divlog == 3'd1);
  c_to_slow: cover property (@(posedge clk) disable iff (!rst_n)
    $past(s_q.act.src) == CSC_SRC_FAST && s_q.act.src == CSC_SRC_SLOW);
  c_fast_to_xtal: cover property (@(posedge clk) disable iff (!rst_n)
    $past(s_q.act.src) == CSC_SRC_FAST && s_q.act.src == CSC_SRC_XTAL);
  c_div_step: cover property (@(posedge clk) disable iff (!rst_n)
    $past(s_q.act.divlog) == 3'd1 && s_q.act.divlog == 3'd2);

endmodule : csc_clock_ctrl

// [tb/csc_osc_model.sv]
// Purpose: Behavioural oscillators at the far side of the clock block
// Assumes: Half periods of five clk cycles or more, so the synchroniser keeps up
// Notes: A stopped oscillator rests low instead of holding its last level
`timescale 1ns/10ps
module csc_osc_model import csc_pkg::*; (
  // Enables from the block
  input wire logic fast_en,
  input wire logic slow_en,
  input wire logic xtal_en,
  input wire logic [1:0] xtal_drive,
  // Oscillator levels
  output logic fast_lvl,
  output logic slow_lvl,
  output logic xtal_lvl
);
  // ==========================================================
  // Free-running cores, gated by their own enables
  logic fast_ring = 1'b0;
  logic slow_ring = 1'b0;
  logic xtal_ring = 1'b0;
  always #20 fast_ring = fast_en ? ~fast_ring : 1'b0;
  always #100 slow_ring = slow_en ? ~slow_ring : 1'b0;
  // Crystal only swings with drive current applied; period kept apart from fast/2
  always #60 xtal_ring = (xtal_en && xtal_drive != 2'h0) ? ~xtal_ring : 1'b0;
  assign fast_lvl = fast_ring;
  assign slow_lvl = slow_ring;
  assign xtal_lvl = xtal_ring;
endmodule : csc_osc_model

// [tb/testbench.sv]
// Purpose: Self-checking bench of the clock select block over AHB-Lite
// Assumes: Oscillator model periods 40 ns fast, 200 ns slow, 120 ns crystal
// Notes: Clock periods are judged within one clk cycle of sampling jitter
`timescale 1ns/10ps
module testbench import csc_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n, ce, hsel, hwrite, hresp, hready_i, frz;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, crystal_drive;
  logic [2:0] hsize, opt;
  logic boot_fast, fast_lvl, slow_lvl, xtal_lvl;
  logic fast_rc_en, slow_rc_en, crystal_en, sys_clk, watchdog_en, pa5_in;
  int mismatches, total_checks;
  localparam logic [31:0] A_CM = 32'h0000000c;
  localparam logic [31:0] A_XC = 32'h0000002c;
  localparam logic [31:0] A_ST = 32'h00000030;
  localparam logic [7:0] BOOT_CM [8] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4,
    CSC_CM_RESET, CSC_CM_BOOT_DIV64};
  localparam int BOOT_PER [8] = '{20, 40, 80, 160, 320, 50, 50, 640};
  localparam logic [7:0] DIV_CM [6] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'h74};

  csc_clock_ctrl csc_clock_ctrl_i (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready_i), .hrdata(hrdata), .hreadyout(hready_i), .hresp(hresp),
    .fast_internal_rc(fast_lvl), .slow_internal_rc(slow_lvl),
    .crystal_oscillator(xtal_lvl), .calibration_directive(opt), .boot_fast(boot_fast),
    .fast_rc_en(fast_rc_en), .slow_rc_en(slow_rc_en), .crystal_en(crystal_en),
    .crystal_drive(crystal_drive), .system_clock_select(sys_clk),
    .watchdog_en(watchdog_en), .port_a_pin_five_input(pa5_in));
  csc_osc_model csc_osc_model_i (.fast_en(fast_rc_en), .slow_en(slow_rc_en),
    .xtal_en(crystal_en), .xtal_drive(crystal_drive), .fast_lvl(fast_lvl),
    .slow_lvl(slow_lvl), .xtal_lvl(xtal_lvl));

  always #2 clk = ~clk;

  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic wait_rdy();
    @(posedge clk);
    while (hready_i !== 1'b1) begin
      @(posedge clk);
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] v;
    bus(1'b1, a, {24'h0, d}, v);
    // Outputs launched by the landing edge are looked at one edge later
    @(posedge clk);
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, exp);
  endtask : rd_chk
  // Cycles between the second and third rise of the system clock
  task automatic per_chk(input int e);
    int n, s, r;
    logic prev;
    n = 0;
    s = 0;
    r = 0;
    prev = sys_clk;
    while (r < 3 && n < 4000) begin
      @(posedge clk);
      n++;
      if (sys_clk === 1'b1 && prev !== 1'b1) begin
        r++;
        if (r == 2) s = n;
      end
      prev = sys_clk;
    end
    check({31'h0, r == 3 && n - s >= e - 1 && n - s <= e + 1}, 32'h1);
  endtask : per_chk
  // Reset, try an early write, then poll for boot done
  task automatic boot(input logic [2:0] o);
    logic [31:0] v;
    int n;
    rst_n <= 1'b0;
    opt <= o;
    boot_fast <= o[0];
    repeat (20) @(posedge clk);
    check({fast_rc_en, slow_rc_en, watchdog_en, crystal_en}, 4'b1110);
    rst_n <= 1'b1;
    // Early write must be dropped until boot is done
    wr(A_XC, 8'he0);
    n = 0;
    v = 32'h0;
    while (v[0] !== 1'b1 && n < 50) begin
      bus(1'b0, A_ST, 32'h0, v);
      n++;
    end
    check(v[0], 1'b1);
    check(v[6:4], o);
    check(v[1], o > CSC_OPT_SLOW);
    check(crystal_en, 1'b0);
  endtask : boot

  // ==========================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    opt = 3'h0;
    boot_fast = 1'b0;
    mismatches = 0;
    total_checks = 0;
    for (int o = 0; o < 8; o++) begin
      boot(o[2:0]);
      rd_chk(A_CM, {24'h0, BOOT_CM[o]});
      check({watchdog_en, slow_rc_en, fast_rc_en, pa5_in}, {o >= 6, 1'b1, o != 5, 1'b1});
      per_chk(BOOT_PER[o]);
    end
    boot(CSC_OPT_SLOW);
    // Old source stays on in each switching write
    wr(A_CM, 8'h34);
    rd_chk(A_CM, 32'h34);
    per_chk(20);
    wr(A_CM, 8'h30);
    check({fast_rc_en, slow_rc_en}, 2'b10);
    per_chk(20);
    wr(A_CM, 8'hf4);
    per_chk(50);
    wr(A_CM, 8'he4);
    check({fast_rc_en, slow_rc_en}, 2'b01);
    for (int i = 0; i < 6; i++) begin
      wr(A_CM, DIV_CM[i]);
      check({fast_rc_en, slow_rc_en}, 2'b11);
      per_chk(20 << i);
    end
    for (int d = 1; d < 4; d++) begin
      wr(A_XC, {1'b1, d[1:0], 5'h0});
      rd_chk(A_XC, {24'h0, 1'b1, d[1:0], 5'h0});
      check({crystal_en, crystal_drive}, {1'b1, d[1:0]});
    end
    // Let the crystal settle before it is chosen
    repeat (400) @(posedge clk);
    wr(A_CM, 8'h34);
    wr(A_CM, 8'hb0);
    per_chk(30);
    wr(A_CM, 8'ha4);
    check({fast_rc_en, slow_rc_en}, 2'b01);
    per_chk(30);
    wr(A_CM, 8'he4);
    per_chk(50);
    // Frozen block keeps its clock level and stalls the bus
    ce <= 1'b0;
    @(posedge clk);
    frz = sys_clk;
    repeat (60) @(posedge clk);
    check({sys_clk, hready_i}, {frz, 1'b0});
    ce <= 1'b1;
    wr(A_XC, 8'h60);
    check(crystal_en, 1'b0);
    rd_chk(32'h00000040, 32'h0);
    wr(32'h00000040, 8'h34);
    rd_chk(A_CM, 32'he4);
    check(hresp, 1'b0);
    finish_test();
  end

  initial begin
    #300000;
    mismatches++;
    finish_test();
  end
endmodule : testbench
